// ==== src/prot_regs_consts.vh ====
// constants of the protector control and status register bank
// assumes a 250 MHz system clock; included by the register bank, the checker and the bench
`ifndef PROT_REGS_CONSTS_VH
`define PROT_REGS_CONSTS_VH

// register offsets on the single-wire memory map
`define OFS_STATUS_DEFAULTS      8'h01
`define OFS_EEPROM_CONTROL_FLAGS 8'h07
`define OFS_SWITCH_TEMP_FLAGS    8'h08
// eeprom block bases (upper six address bits) and init byte index
`define EE_BLOCK0_BASE           6'h08
`define EE_BLOCK1_BASE           6'h0C
`define EE_INIT_IDX              3'h5

// status register fields
`define ST_FIXED_HI_BIT          5
`define ST_OPSEL_BIT             4
`define ST_FIXED_LO_BIT          3
// eeprom control register fields
`define EE_BUSY_BIT              7
`define EE_ARM_BIT               6
`define EE_BL1_BIT               1
`define EE_BL0_BIT               0
// switch and temperature register fields
`define SF_PSF_BIT               7
`define SF_OT_BIT                0

// reset values of the volatile flags
`define PSF_RESET                1'b1
`define OT_RESET                 1'b0
`define ARM_RESET                1'b0

// read net address opcodes chosen by the select bit
`define NET_READ_OPCODE_0        8'h33
`define NET_READ_OPCODE_1        8'h39

// function command codes on the command port
`define FN_WRITE                 3'h0
`define FN_READ                  3'h1
`define FN_COPY                  3'h2
`define FN_RECALL                3'h3
`define FN_LOCK                  3'h4

// timing: bus low time taken as a reset pulse, and eeprom copy time
`define CLK_MHZ                  250
`define BUS_RESET_LOW_NS         120000
`define BUS_RESET_CYCLES         ((`BUS_RESET_LOW_NS * `CLK_MHZ) / 1000)
`define COPY_CYCLES_DEFAULT      64

`endif

// ==== src/pin_sync2.v ====
// two flip-flop synchroniser for asynchronous pin levels
// assumes inputs are slow levels coming from outside the clock domain
`timescale 1ns/1ps

module pin_sync2 #(
  parameter WIDTH = 2,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b1}}
) (
  // clock and reset
  input  wire             sys_clk_i,
  input  wire             reset_i,
  // raw pins and synchronised levels
  input  wire [WIDTH-1:0] pin_i,
  output wire [WIDTH-1:0] level_o
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] level_r;

  // first stage feeds only the second stage
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_r  <= RESET_VAL;
      level_r <= RESET_VAL;
    end else begin
      meta_r  <= pin_i;
      level_r <= meta_r;
    end
  end

  assign level_o = level_r;

endmodule // pin_sync2

// ==== src/protector_status_lock_regs.v ====
// status, eeprom control and special feature registers of a battery protector
// assumes a bit engine in front decodes the single-wire bus into function
// commands and asks for the data line to be pulled low; pins arrive raw
`timescale 1ns/1ps
`include "prot_regs_consts.vh"

// Operation
// R01: recall of eeprom block 1 reloads status bits from the init byte.
// R02: status bits 5 and 3 are read-only copies of init byte bits.
// R03: select bit 4 picks opcode 33h when 0, 39h when 1.
// R04: select default comes from init byte bit 4, written by the host.
// R05: copy busy flag reads 1 during a copy; eeprom writes ignored then.
// R06: eeprom writes accepted only when unlocked, not busy and active.
// R07: lock arm bit is writable; lock command ignored while it is 0.
// R08: lock arm clears after a lock and after power-on reset.
// R09: block 1 lock flag reads 1 when block 1 is locked.
// R10: block 0 lock flag reads 1 when block 0 is locked.
// R11: switch flag clears on sense pin low, host writes 1 to re-arm.
// R12: overtemp flag sets on event and stays until host clears it.
// R13: writing 1 to overtemp flag turns both fets off.
// R14: sense pin low wakes from sleep, no effect while active.
// R15: device is always a slave on the single-wire bus.
// R16: 64-bit address: family byte low, 48-bit serial, crc byte high.
// R17: host crc starts at zero, shifts 56 bits in lsb first.
// R18: device never checks the address crc nor blocks on mismatch.
// R19: data line driven only open-drain: pulled low or released.
// R20: master leaves the line high idle when suspending a transaction.
// R21: line low longer than 120 us is a reset, ending the transaction.
// R22: lock works only right after the write that set the arm bit.
// R23: read net address answers only to the currently selected opcode.
// R24: host crc uses x8+x5+x4+1 with input xor low bit feedback.
// R25: reserved bits read as zero; writes to them are ignored.
module protector_status_lock_regs #(
  parameter        [7:0]  FAMILY_CODE      = 8'h5A,           // arbitrary value
  parameter        [47:0] SERIAL_NUMBER    = 48'h0000_0001_2345, // arbitrary value
  parameter integer       RESET_LOW_CYCLES = `BUS_RESET_CYCLES,
  parameter integer       COPY_CYCLES      = `COPY_CYCLES_DEFAULT
) (
  // clock and reset
  input  wire        sys_clk_i,
  input  wire        reset_i,
  // single-wire data pin, open-drain
  input  wire        dq_i,
  output reg         dq_o,
  output reg         dq_oe_o,
  // power switch sense pin, active low
  input  wire        power_switch_sense_pin_n_i,
  // from the protection and power logic and the bit engine
  input  wire        overtemp_event_i,
  input  wire        sleep_mode_i,
  input  wire        bit_engine_pull_low_i,
  // decoded function commands from the bit engine
  input  wire        fn_valid_i,
  input  wire [2:0]  fn_op_i,
  input  wire [7:0]  fn_addr_i,
  input  wire [7:0]  fn_wdata_i,
  output reg         fn_ack_o,
  output reg  [7:0]  fn_rdata_o,
  // status towards the bit engine and the fet drivers
  output reg  [7:0]  net_read_opcode_o,
  output reg  [63:0] net_address_o,
  output reg         bus_reset_o,
  output reg         wake_o,
  output reg         fets_off_o,
  output reg         copy_busy_flag_o
);

  // crc of the first 56 address bits, lsb first, reflected x8+x5+x4+1
  function [7:0] addr_crc;
    input [55:0] bits;
    integer      i;
    reg   [7:0]  c;
    reg          fb;
    begin
      c = 8'h00;
      for (i = 0; i < 56; i = i + 1) begin
        fb = c[0] ^ bits[i];
        c  = {1'b0, c[7:1]};
        if (fb) begin
          c = c ^ 8'h8C;
        end
      end
      addr_crc = c;
    end
  endfunction

  // address image and counter limits
  localparam [55:0] ADDR_LOW56 = {SERIAL_NUMBER, FAMILY_CODE};
  localparam [63:0] NET_ADDR   = {addr_crc(ADDR_LOW56), ADDR_LOW56};
  localparam [15:0] LOW_LIMIT  = RESET_LOW_CYCLES[15:0];
  localparam [15:0] COPY_LAST  = COPY_CYCLES[15:0] - 16'h0001;

  // synchronised pin levels
  wire [1:0] pins_s;
  wire       dq_s;
  wire       ps_low_s;

  pin_sync2 #(
    .WIDTH     (2),
    .RESET_VAL (2'b11)
  ) u_pin_sync (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .pin_i     ({power_switch_sense_pin_n_i, dq_i}),
    .level_o   (pins_s)
  );

  // bit 0 carries the data line, bit 1 the sense pin
  assign dq_s     = pins_s[0];
  assign ps_low_s = ~pins_s[1];

  // shadow ram, eeprom cells and block locks
  reg  [7:0]  shadow_r [0:7];
  reg  [7:0]  eeprom_r [0:7];
  reg  [1:0]  locked_r;
  // status bits and their power-up load
  reg         st_fixed_hi_r;
  reg         net_address_read_opcode_select_r;
  reg         st_fixed_lo_r;
  reg         init_pending_r;
  // lock arm pairing
  reg         lock_arm_r;
  reg         arm_just_set_r;
  // flags, copy timer and bus low timer
  reg         power_switch_event_flag_r;
  reg         overtemp_flag_r;
  reg  [15:0] copy_cnt_r;
  reg         copy_blk_r;
  reg  [15:0] low_cnt_r;

  // address decode of the current command
  wire        is_ee    = (fn_addr_i[7:2] == `EE_BLOCK0_BASE) ||
                         (fn_addr_i[7:2] == `EE_BLOCK1_BASE);
  wire        blk      = fn_addr_i[4];
  wire [2:0]  ee_idx   = {blk, fn_addr_i[1:0]};
  wire        active   = ~sleep_mode_i;
  wire        do_write = fn_valid_i && (fn_op_i == `FN_WRITE);
  wire        do_read  = fn_valid_i && (fn_op_i == `FN_READ);
  wire        do_copy  = fn_valid_i && (fn_op_i == `FN_COPY) && is_ee && active &&
                         !locked_r[blk] && !copy_busy_flag_o;
  wire        do_recall = fn_valid_i && (fn_op_i == `FN_RECALL) && is_ee;
  wire        do_lock  = fn_valid_i && (fn_op_i == `FN_LOCK) && active;
  wire        ee_write_ok = do_write && is_ee && active && !locked_r[blk] &&
                            !copy_busy_flag_o;                                // R06 R05
  wire        copy_done = copy_busy_flag_o && (copy_cnt_r == 16'h0000);

  // per-entry strobes: host write, block recall, copy commit
  wire [7:0]  idx_hot  = 8'h01 << ee_idx;
  wire [1:0]  blk_hot  = blk ? 2'b10 : 2'b01;
  wire [1:0]  copy_hot = copy_blk_r ? 2'b10 : 2'b01;
  wire [7:0]  host_we;
  wire [7:0]  recall_we;
  wire [7:0]  commit_we;

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_entry
      assign host_we[g]   = ee_write_ok && idx_hot[g];                       // R06
      // recall reloads a whole block whether locked or not
      assign recall_we[g] = do_recall && blk_hot[g / 4];
      assign commit_we[g] = copy_done && copy_hot[g / 4];
    end
  endgenerate

  // register read image
  reg  [7:0]  rd_image;

  always @* begin
    rd_image = 8'h00;                                                         // R25
    if (fn_addr_i == `OFS_STATUS_DEFAULTS) begin
      rd_image[`ST_FIXED_HI_BIT] = st_fixed_hi_r;                             // R02
      rd_image[`ST_OPSEL_BIT]    = net_address_read_opcode_select_r;          // R03
      rd_image[`ST_FIXED_LO_BIT] = st_fixed_lo_r;                             // R02
    end else if (fn_addr_i == `OFS_EEPROM_CONTROL_FLAGS) begin
      rd_image[`EE_BUSY_BIT] = copy_busy_flag_o;                              // R05
      rd_image[`EE_ARM_BIT]  = lock_arm_r;
      rd_image[`EE_BL1_BIT]  = locked_r[1];                                   // R09
      rd_image[`EE_BL0_BIT]  = locked_r[0];                                   // R10
    end else if (fn_addr_i == `OFS_SWITCH_TEMP_FLAGS) begin
      rd_image[`SF_PSF_BIT] = power_switch_event_flag_r;
      rd_image[`SF_OT_BIT]  = overtemp_flag_r;
    end else if (is_ee) begin
      // eeprom reads always see the shadow ram
      rd_image = shadow_r[ee_idx];
    end
  end

  // eeprom, shadow ram and lock state; copies and recalls move whole blocks
  integer k;

  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (k = 0; k < 8; k = k + 1) begin
        shadow_r[k] <= 8'h00;
        eeprom_r[k] <= 8'h00;
      end
      locked_r         <= 2'b00;
      copy_cnt_r       <= 16'h0000;
      copy_blk_r       <= 1'b0;
      copy_busy_flag_o <= 1'b0;
    end else begin
      // per entry: recall beats a host write, copy commits to eeprom
      for (k = 0; k < 8; k = k + 1) begin
        if (recall_we[k]) begin
          shadow_r[k] <= eeprom_r[k];
        end else if (host_we[k]) begin
          shadow_r[k] <= fn_wdata_i;                                          // R06
        end
        if (commit_we[k]) begin
          eeprom_r[k] <= shadow_r[k];
        end
      end
      // copy start and completion
      if (do_copy) begin
        copy_busy_flag_o <= 1'b1;                                             // R05
        copy_cnt_r       <= COPY_LAST;
        copy_blk_r       <= blk;
      end else if (copy_done) begin
        copy_busy_flag_o <= 1'b0;
      end else if (copy_busy_flag_o) begin
        copy_cnt_r <= copy_cnt_r - 16'h0001;
      end
      // lock is permanent and needs the arm write just before it
      if (do_lock && is_ee && lock_arm_r && arm_just_set_r) begin
        locked_r[blk] <= 1'b1;                                                // R22 R09 R10
      end
    end
  end

  // status bits follow the init byte at power-on and on block 1 recall
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      init_pending_r                   <= 1'b1;
      st_fixed_hi_r                    <= 1'b0;
      net_address_read_opcode_select_r <= 1'b0;
      st_fixed_lo_r                    <= 1'b0;
    end else if (init_pending_r || (do_recall && blk)) begin
      init_pending_r                   <= 1'b0;
      st_fixed_hi_r                    <= eeprom_r[`EE_INIT_IDX][`ST_FIXED_HI_BIT]; // R01 R02
      net_address_read_opcode_select_r <= eeprom_r[`EE_INIT_IDX][`ST_OPSEL_BIT];    // R01 R04
      st_fixed_lo_r                    <= eeprom_r[`EE_INIT_IDX][`ST_FIXED_LO_BIT]; // R01 R02
    end
  end

  // lock arm bit and the immediately-preceding tracker
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lock_arm_r     <= `ARM_RESET;                                           // R08
      arm_just_set_r <= 1'b0;
    end else begin
      // any command or a bus reset breaks the arm-then-lock pairing
      if (fn_valid_i || bus_reset_o) begin
        arm_just_set_r <= 1'b0;                                               // R21 R22
      end
      // the arm write itself still lands when a bus reset coincides
      if (do_write && (fn_addr_i == `OFS_EEPROM_CONTROL_FLAGS)) begin
        lock_arm_r     <= fn_wdata_i[`EE_ARM_BIT];                            // R07
        arm_just_set_r <= fn_wdata_i[`EE_ARM_BIT] && !bus_reset_o;            // R22
      end else if (do_lock && lock_arm_r) begin
        lock_arm_r <= 1'b0;                                                   // R08
      end
    end
  end

  // switch flag: pin low clears it and wins over a host re-arm
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      power_switch_event_flag_r <= `PSF_RESET;                                // R11
    end else if (ps_low_s) begin
      power_switch_event_flag_r <= 1'b0;                                      // R11
    end else if (do_write && (fn_addr_i == `OFS_SWITCH_TEMP_FLAGS)) begin
      power_switch_event_flag_r <= fn_wdata_i[`SF_PSF_BIT];                   // R11
    end
  end

  // overtemp flag: event sets and wins over a host clear
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      overtemp_flag_r <= `OT_RESET;                                           // R12
    end else if (overtemp_event_i) begin
      overtemp_flag_r <= 1'b1;                                                // R12
    end else if (do_write && (fn_addr_i == `OFS_SWITCH_TEMP_FLAGS)) begin
      overtemp_flag_r <= fn_wdata_i[`SF_OT_BIT];                              // R12 R13
    end
  end

  // bus low timer: long low is a reset pulse, reported once per low period
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      low_cnt_r   <= 16'h0000;
      bus_reset_o <= 1'b0;
    end else begin
      bus_reset_o <= 1'b0;
      if (dq_s) begin
        low_cnt_r <= 16'h0000;
      end else if (low_cnt_r != LOW_LIMIT + 16'h0001) begin
        low_cnt_r <= low_cnt_r + 16'h0001;
        if (low_cnt_r == LOW_LIMIT) begin
          bus_reset_o <= 1'b1;                                                // R21
        end
      end
    end
  end

  // command answers, registered one cycle after the command
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      fn_ack_o   <= 1'b0;
      fn_rdata_o <= 8'h00;
    end else begin
      fn_ack_o <= fn_valid_i;
      if (do_read) begin
        fn_rdata_o <= rd_image;
      end
    end
  end

  // outward status: opcode, address, wake and fet shutdown
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      net_read_opcode_o <= `NET_READ_OPCODE_0;
      net_address_o     <= 64'h0000_0000_0000_0000;
      wake_o            <= 1'b0;
      fets_off_o        <= 1'b0;
    end else begin
      net_read_opcode_o <= net_address_read_opcode_select_r ?
                           `NET_READ_OPCODE_1 : `NET_READ_OPCODE_0;          // R03 R23
      net_address_o     <= NET_ADDR;                                          // R16 R18
      wake_o            <= ps_low_s && sleep_mode_i;                          // R14
      fets_off_o        <= overtemp_flag_r;                                   // R12 R13
    end
  end

  // open-drain data line: only ever pulled low, else released
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dq_o    <= 1'b0;
      dq_oe_o <= 1'b0;
    end else begin
      dq_o    <= 1'b0;                                                        // R19
      dq_oe_o <= bit_engine_pull_low_i && !bus_reset_o;                       // R19 R15
    end
  end

endmodule // protector_status_lock_regs

// ==== verif/prot_regs_chk.sv ====
// port checker for the protector register bank
// assumes one clock domain; bound to the bank's top module
`timescale 1ns/1ps
`include "prot_regs_consts.vh"
module prot_regs_chk #(
  parameter integer RESET_LOW_CYCLES = 20,
  parameter integer COPY_CYCLES      = 4
) (
  // clock and reset
  input wire       sys_clk_i,
  input wire       reset_i,
  // pins and side inputs
  input wire       dq_i,
  input wire       dq_o,
  input wire       dq_oe_o,
  input wire       power_switch_sense_pin_n_i,
  input wire       overtemp_event_i,
  input wire       sleep_mode_i,
  input wire       bit_engine_pull_low_i,
  // command port and status
  input wire       fn_valid_i,
  input wire       fn_ack_o,
  input wire [7:0] net_read_opcode_o,
  input wire       bus_reset_o,
  input wire       wake_o,
  input wire       fets_off_o,
  input wire       copy_busy_flag_o
);
  reg [15:0] low_cnt_r;
  reg [7:0]  busy_len_r;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);
  // run lengths of a low line and of a busy copy
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      low_cnt_r  <= 16'h0000;
      busy_len_r <= 8'h00;
    end else begin
      low_cnt_r  <= dq_i ? 16'h0000 : low_cnt_r + 16'h0001;
      busy_len_r <= copy_busy_flag_o ? busy_len_r + 8'h01 : 8'h00;
    end
  end
  sequence s_cmd;
    fn_valid_i;
  endsequence
  sequence s_sense_sleep;
    (!power_switch_sense_pin_n_i && sleep_mode_i) [*4];
  endsequence
  a_ack_after_cmd: assert property (s_cmd |=> fn_ack_o)
    else $error("ack missing after command");
  a_ack_no_cmd: assert property (!fn_valid_i |=> !fn_ack_o)
    else $error("ack without command");
  a_opcode_legal: assert property (net_read_opcode_o == `NET_READ_OPCODE_0
    || net_read_opcode_o == `NET_READ_OPCODE_1) else $error("bad read opcode");
  a_dq_drain_only: assert property (dq_o == 1'b0)
    else $error("data pin driven high");
  a_oe_follows_req: assert property (!$past(bus_reset_o)
    |-> dq_oe_o == $past(bit_engine_pull_low_i)) else $error("pull low not followed");
  a_fets_on_ot: assert property (overtemp_event_i |=> ##1 fets_off_o)
    else $error("fets not off after overtemp");
  a_no_wake_active: assert property (!$past(sleep_mode_i) |-> !wake_o)
    else $error("wake while active");
  a_wake_on_sense: assert property (s_sense_sleep |=> wake_o)
    else $error("no wake on sense low");
  a_reset_one_pulse: assert property (bus_reset_o |=> !bus_reset_o)
    else $error("bus reset longer than a cycle");
  a_reset_low_len: assert property (bus_reset_o |-> low_cnt_r >= RESET_LOW_CYCLES
    && low_cnt_r <= RESET_LOW_CYCLES + 6) else $error("bus reset at wrong low length");
  a_copy_busy_len: assert property ($fell(copy_busy_flag_o) |-> busy_len_r == COPY_CYCLES)
    else $error("copy busy length wrong");
endmodule // prot_regs_chk

bind protector_status_lock_regs prot_regs_chk #(
  .RESET_LOW_CYCLES(RESET_LOW_CYCLES),
  .COPY_CYCLES     (COPY_CYCLES)
) u_chk (
  .sys_clk_i, .reset_i, .dq_i, .dq_o, .dq_oe_o, .power_switch_sense_pin_n_i,
  .overtemp_event_i, .sleep_mode_i, .bit_engine_pull_low_i, .fn_valid_i, .fn_ack_o,
  .net_read_opcode_o, .bus_reset_o, .wake_o, .fets_off_o, .copy_busy_flag_o
);

// ==== verif/bus_master_model.sv ====
// host side stand-in: pulled-up single line and host address crc
// assumes the bench tells it when to hold the line low
`timescale 1ns/1ps
module bus_master_model #(
  parameter [55:0] ADDR_LOW = 56'h0
) (
  // line control
  input  wire       hold_low_i,
  input  wire       dut_oe_i,
  input  wire       dut_drive_i,
  // line level and host crc
  output wire       dq_line_o,
  output wire [7:0] crc_o
);
  // clear, then 56 bits lsb first, feedback is input xor low bit
  function [7:0] crc56(input [55:0] v);
    integer i;
    reg     fb;
    begin
      crc56 = 8'h00;
      for (i = 0; i < 56; i = i + 1) begin
        fb    = crc56[0] ^ v[i];
        crc56 = {fb, crc56[7:1]} ^ (fb ? 8'h0C : 8'h00);
      end
    end
  endfunction
  // pull-up wins unless a party pulls low; line idles high
  assign dq_line_o = !(hold_low_i || (dut_oe_i && !dut_drive_i));
  assign crc_o     = crc56(ADDR_LOW);
endmodule // bus_master_model

// ==== verif/protector_status_lock_regs_tb_top.sv ====
// self-checking bench for the protector register bank
// assumes commands from a bit engine; inputs change on falling edges
`timescale 1ns/1ps
`include "prot_regs_consts.vh"
module protector_status_lock_regs_tb_top;
  localparam [7:0]  FAMILY = 8'h6B;              // arbitrary value
  localparam [47:0] SERIAL = 48'h0000_00A1_B2C3; // arbitrary value
  reg         sys_clk_i, reset_i, sense_n, ot_ev, sleep, pull_low, hold_low, fn_valid;
  reg  [2:0]  fn_op;
  reg  [7:0]  fn_addr, fn_wdata, d;
  reg  [8:0]  notes [$];
  reg  [8:0]  note;
  integer     fails, n_tests, cycles, n_bus_rst;
  wire        dq_line, dq_o, dq_oe_o, fn_ack_o, bus_reset_o, wake_o, fets_off_o, busy;
  wire [7:0]  fn_rdata_o, op_o, crc;
  wire [63:0] net_addr;

  protector_status_lock_regs #(.FAMILY_CODE(FAMILY), .SERIAL_NUMBER(SERIAL),
    .RESET_LOW_CYCLES(20), .COPY_CYCLES(4)) dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .dq_i(dq_line), .dq_o(dq_o),
    .dq_oe_o(dq_oe_o), .power_switch_sense_pin_n_i(sense_n), .overtemp_event_i(ot_ev),
    .sleep_mode_i(sleep), .bit_engine_pull_low_i(pull_low), .fn_valid_i(fn_valid),
    .fn_op_i(fn_op), .fn_addr_i(fn_addr), .fn_wdata_i(fn_wdata), .fn_ack_o(fn_ack_o),
    .fn_rdata_o(fn_rdata_o), .net_read_opcode_o(op_o), .net_address_o(net_addr),
    .bus_reset_o(bus_reset_o), .wake_o(wake_o), .fets_off_o(fets_off_o),
    .copy_busy_flag_o(busy));
  bus_master_model #(.ADDR_LOW({SERIAL, FAMILY})) u_host (.hold_low_i(hold_low),
    .dut_oe_i(dq_oe_o), .dut_drive_i(dq_o), .dq_line_o(dq_line), .crc_o(crc));

  // 250 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  task chk(input string name, input [63:0] exp, input [63:0] got);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task end_sim;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // one command per cycle; the note tells the monitor what ack brings
  task cmd(input [2:0] op, input [7:0] a, input [7:0] wd, input [8:0] nt);
    begin
      fn_valid = 1'b1;
      fn_op    = op;
      fn_addr  = a;
      fn_wdata = wd;
      notes.push_back(nt);
      @(negedge sys_clk_i);
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    cmd(`FN_WRITE, a, v, 9'h000);
  endtask
  task rd(input [7:0] a, input [7:0] e);
    cmd(`FN_READ, a, 8'h00, {1'b1, e});
  endtask
  task op(input [2:0] o, input [7:0] a);
    cmd(o, a, 8'h00, 9'h000);
  endtask
  task idle(input integer n);
    begin
      fn_valid = 1'b0;
      repeat (n) @(negedge sys_clk_i);
    end
  endtask

  // monitor: each ack takes the oldest note
  always @(negedge sys_clk_i) begin
    if (fn_ack_o === 1'b1) begin
      note = notes.pop_front();
      if (note[8]) chk("read data", {56'h0, note[7:0]}, {56'h0, fn_rdata_o});
    end
  end
  // random pull requests, bus reset count and hang guard
  always @(negedge sys_clk_i) pull_low <= !reset_i && ($urandom % 4 == 0);
  always @(posedge sys_clk_i) begin
    cycles = cycles + 1;
    if (bus_reset_o === 1'b1) n_bus_rst = n_bus_rst + 1;
    if (cycles == 3000) begin
      fails = fails + 1;
      end_sim;
    end
  end

  initial begin
    {reset_i, sense_n} = 2'b11;
    {ot_ev, sleep, pull_low, hold_low, fn_valid} = 5'b00000;
    {fn_op, fn_addr, fn_wdata} = 19'h0_0000;
    {fails, n_tests, cycles, n_bus_rst} = 128'h0;
    d = $urandom(93543);
    repeat (10) @(negedge sys_clk_i);
    reset_i = 1'b0;
    idle(2);
    rd(8'h01, 8'h00);
    rd(8'h07, 8'h00);
    rd(8'h08, 8'h80);
    chk("opcode", 8'h33, op_o);
    chk("net address", {crc, SERIAL, FAMILY}, net_addr);
    d = $urandom;
    wr(8'h08, d);
    rd(8'h08, {d[7], 6'h00, d[0]});
    idle(2);
    chk("fets off", d[0], fets_off_o);
    wr(8'h08, 8'h80);
    ot_ev = 1'b1;
    idle(1);
    ot_ev = 1'b0;
    rd(8'h08, 8'h81);
    chk("fets off", 1'b1, fets_off_o);
    wr(8'h08, 8'h80);
    rd(8'h08, 8'h80);
    sense_n = 1'b0;
    idle(6);
    chk("wake", 1'b0, wake_o);
    sleep = 1'b1;
    idle(5);
    chk("wake", 1'b1, wake_o);
    {sense_n, sleep} = 2'b10;
    idle(4);
    rd(8'h08, 8'h00);
    wr(8'h08, 8'h80);
    rd(8'h08, 8'h80);
    wr(8'h01, 8'hFF);
    rd(8'h01, 8'h00);
    wr(8'h31, 8'h10);
    rd(8'h31, 8'h10);
    op(`FN_COPY, 8'h30);
    rd(8'h07, 8'h80);
    wr(8'h32, 8'h77);
    chk("copy busy", 1'b1, busy);
    idle(6);
    rd(8'h32, 8'h00);
    op(`FN_RECALL, 8'h30);
    idle(2);
    rd(8'h01, 8'h10);
    chk("opcode", 8'h39, op_o);
    sleep = 1'b1;
    wr(8'h33, 8'h5A);
    sleep = 1'b0;
    rd(8'h33, 8'h00);
    wr(8'h33, 8'h5A);
    rd(8'h33, 8'h5A);
    op(`FN_LOCK, 8'h30);
    rd(8'h07, 8'h00);
    wr(8'h07, 8'h40);
    rd(8'h07, 8'h40);
    op(`FN_LOCK, 8'h20);
    rd(8'h07, 8'h00);
    wr(8'h07, 8'h40);
    op(`FN_LOCK, 8'h20);
    rd(8'h07, 8'h01);
    wr(8'h20, 8'hAA);
    rd(8'h20, 8'h00);
    wr(8'h07, 8'h40);
    op(`FN_LOCK, 8'h30);
    rd(8'h07, 8'h03);
    wr(8'h31, 8'h00);
    rd(8'h31, 8'h10);
    op(3'h5, 8'h00);
    hold_low = 1'b1;
    idle(30);
    hold_low = 1'b0;
    idle(8);
    chk("bus resets", 64'd1, n_bus_rst);
    end_sim;
  end
endmodule // protector_status_lock_regs_tb_top
